// >>> include/etac_pkg.sv
// package for the exposure trigger and acquisition control block
// assumes a 200 MHz pclk and an apb master with 32-bit data
package etac_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] ETAC_CMD_OFS      = 12'h000;
	localparam logic [11:0] ETAC_CFG_OFS      = 12'h004;
	localparam logic [11:0] ETAC_EXPT_OFS     = 12'h008;
	localparam logic [11:0] ETAC_PERIOD_OFS   = 12'h00C;
	localparam logic [11:0] ETAC_MINPER_OFS   = 12'h010;
	localparam logic [11:0] ETAC_TDLY_OFS     = 12'h014;
	localparam logic [11:0] ETAC_STAT_OFS     = 12'h018;
	localparam logic [11:0] ETAC_FCNT_OFS     = 12'h01C;
	// ----------------------------------------------------------------
	// command bits (write one to execute)
	// ----------------------------------------------------------------
	localparam int ETAC_CMD_ARM_BIT    = 0;
	localparam int ETAC_CMD_DISARM_BIT = 1;
	localparam int ETAC_CMD_SWTRIG_BIT = 2;
	// ----------------------------------------------------------------
	// config fields
	// ----------------------------------------------------------------
	localparam int ETAC_CFG_MODE_BIT   = 0;
	localparam int ETAC_CFG_ACT_BIT    = 1;
	localparam int ETAC_CFG_EXPM_BIT   = 2;
	localparam int ETAC_CFG_HOUT_BIT   = 3;
	localparam int ETAC_CFG_SRC_LSB    = 8;
	localparam int ETAC_CFG_SRC_W      = 5;
	// ----------------------------------------------------------------
	// trigger source codes
	// ----------------------------------------------------------------
	localparam logic [4:0] ETAC_SRC_SW    = 5'h03;
	localparam logic [4:0] ETAC_SRC_HOUT  = 5'h0A;
	localparam logic [4:0] ETAC_SRC_CC1   = 5'h0E;
	localparam logic [4:0] ETAC_SRC_TIMER = 5'h12;
	localparam logic [4:0] ETAC_SRC_LINE  = 5'h16;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] ETAC_CFG_RST    = 32'h0000_1600;
	localparam logic [31:0] ETAC_EXPT_RST   = 32'h0000_03E8;
	localparam logic [31:0] ETAC_PERIOD_RST = 32'h0000_2710;
	localparam logic [31:0] ETAC_MINPER_RST = 32'h0000_0001;
	localparam logic [31:0] ETAC_TDLY_RST   = 32'h0000_0000;
	// ----------------------------------------------------------------
	// timing: settings count microseconds
	// ----------------------------------------------------------------
	localparam int ETAC_CLK_MHZ    = 200;
	localparam int ETAC_US_NS      = 1000;
	localparam int ETAC_CLK_NS     = ETAC_US_NS / ETAC_CLK_MHZ;
	localparam int ETAC_US_CYCLES  = ETAC_US_NS / ETAC_CLK_NS;
	localparam logic [31:0] ETAC_EXPT_MIN_US = 32'h0000_0001;
	typedef enum logic [1:0] {
		ETAC_IDLE,
		ETAC_WAIT,
		ETAC_EXPOSE,
		ETAC_BUSY
	} etac_state_type;
endpackage

// >>> rtl/etac_ctrl.sv
// acquisition arm/disarm and exposure-start trigger control, apb slave
// assumes inputs synchronous to pclk; sensor_busy high during readout
//
// Summary of operation
// - no frame starts before arm; triggers before that are dropped
// - disarm while idle stops acquisition at once
// - disarm during a frame lets it finish, then stops
// - arm during a frame still in progress is ignored
// - armed, one frame per trigger taken while waiting, until disarm
// - trigger mode: 0 internal, 1 external
// - trigger mode changes only while disarmed
// - mode off: internal triggers from arm until disarm
// - free-run at set rate, limited to the maximum allowed rate
// - mode off: exposure equals exposure-time setting
// - source codes 3 software, 10 user bit, 14 cc1, 22 line
// - each software command gives one trigger
// - timer source delays the line trigger by timer delay
// - activation 1 rising edge, 0 falling edge
// - software source uses the exposure-time setting
// - cc1/line: timed uses setting, width follows signal
// - user bit in width mode: exposure follows toggles
// - leave waiting on exposure, return when ready again
// - triggers while not ready are ignored
// - cc1 edge of chosen polarity starts a frame when waiting
// - exposure time in microseconds, at least one
// - width mode: active edge starts, opposite edge ends
//
// Implementation choices: the APB register port and the register offsets.
module etac_ctrl
	import etac_pkg::*;
#(
	parameter int US_CYCLES = ETAC_US_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cc1,
	input  wire logic        hw_trig_line,
	input  wire logic        sensor_busy,
	output logic             exposure,
	output logic             frame_start,
	output logic             acq_armed
);
	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [31:0]    cfg_reg, expt_reg, period_reg, minper_reg, tdly_reg;
	logic [31:0]    fcnt_reg;
	logic [31:0]    prdata_reg;
	logic           pready_reg, pslverr_reg;
	logic           armed_reg, stop_pend_reg;
	etac_state_type state_reg, state_next;
	logic [31:0]    exp_cnt_reg, fr_cnt_reg, dly_cnt_reg;
	logic [7:0]     us_cnt_reg;
	logic           dly_run_reg, dly_fire_reg;
	logic           cc1_q_reg, line_q_reg, hout_q_reg;
	logic           exp_reg, fs_reg;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire access  = psel && penable && !pready_reg;
	// writes land on the completing edge, where pready is seen high
	wire wr      = psel && penable && pready_reg && pwrite;
	wire hit_cmd = paddr == ETAC_CMD_OFS;
	wire hit_cfg = paddr == ETAC_CFG_OFS;
	wire hit_exp = paddr == ETAC_EXPT_OFS;
	wire hit_per = paddr == ETAC_PERIOD_OFS;
	wire hit_min = paddr == ETAC_MINPER_OFS;
	wire hit_dly = paddr == ETAC_TDLY_OFS;
	wire hit_st  = paddr == ETAC_STAT_OFS;
	wire hit_fc  = paddr == ETAC_FCNT_OFS;
	wire mapped  = hit_cmd | hit_cfg | hit_exp | hit_per | hit_min | hit_dly
		| hit_st | hit_fc;
	wire cmd_arm    = wr && hit_cmd && pwdata[ETAC_CMD_ARM_BIT];
	wire cmd_disarm = wr && hit_cmd && pwdata[ETAC_CMD_DISARM_BIT];
	wire cmd_swtrig = wr && hit_cmd && pwdata[ETAC_CMD_SWTRIG_BIT];

	// ----------------------------------------------------------------
	// configuration fields
	// ----------------------------------------------------------------
	wire       trig_mode = cfg_reg[ETAC_CFG_MODE_BIT];
	wire       act_rise  = cfg_reg[ETAC_CFG_ACT_BIT];
	wire       width_md  = cfg_reg[ETAC_CFG_EXPM_BIT];
	wire       host_out_bit = cfg_reg[ETAC_CFG_HOUT_BIT];
	wire [4:0] src = cfg_reg[ETAC_CFG_SRC_LSB +: ETAC_CFG_SRC_W];

	// edge of chosen polarity; cur/prev of the selected level
	function automatic logic act_edge(input logic cur, input logic prev,
		input logic rise);
		act_edge = rise ? (cur && !prev) : (!cur && prev);
	endfunction

	// ----------------------------------------------------------------
	// trigger source selection
	// ----------------------------------------------------------------
	wire sel_sw   = src == ETAC_SRC_SW;
	wire sel_hout = src == ETAC_SRC_HOUT;
	wire sel_cc1  = src == ETAC_SRC_CC1;
	wire sel_line = src == ETAC_SRC_LINE;
	wire sel_tmr  = src == ETAC_SRC_TIMER;
	// selected electrical level; timer source forwards delayed line edge
	wire lvl_cur  = sel_cc1 ? cc1 : sel_hout ? host_out_bit : hw_trig_line;
	wire lvl_prev = sel_cc1 ? cc1_q_reg : sel_hout ? hout_q_reg : line_q_reg;
	wire line_edge = act_edge(hw_trig_line, line_q_reg, act_rise);
	wire delayed_line_trig = dly_fire_reg;
	wire ext_edge = act_edge(lvl_cur, lvl_prev, act_rise);
	wire level_end = act_edge(lvl_cur, lvl_prev, !act_rise);
	wire fr_tick  = fr_cnt_reg == 32'h0000_0000;
	wire trig_in  = !trig_mode ? fr_tick
		: sel_sw ? cmd_swtrig
		: sel_tmr ? delayed_line_trig
		: (sel_cc1 || sel_line || sel_hout) ? ext_edge : 1'b0;
	wire use_width = trig_mode && width_md && (sel_cc1 || sel_line || sel_hout);
	// exposure in microseconds, at least one microsecond
	wire [31:0] expt_us = (expt_reg < ETAC_EXPT_MIN_US) ? ETAC_EXPT_MIN_US : expt_reg;
	wire us_tick = us_cnt_reg == 8'(US_CYCLES - 1);
	// free-run period: the larger of set period and minimum period
	wire [31:0] per_us = (period_reg < minper_reg) ? minper_reg : period_reg;
	wire exp_done = use_width ? level_end
		: (us_tick && exp_cnt_reg == 32'h0000_0001);

	// ----------------------------------------------------------------
	// acquisition state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ETAC_IDLE:
				if (cmd_arm) begin
					state_next = ETAC_WAIT;
				end
			ETAC_WAIT:
				if (cmd_disarm || !armed_reg) begin
					state_next = ETAC_IDLE;
				end else if (trig_in) begin
					state_next = ETAC_EXPOSE;
				end
			ETAC_EXPOSE:
				if (exp_done) begin
					state_next = ETAC_BUSY;
				end
			ETAC_BUSY:
				if (!sensor_busy) begin
					state_next = (stop_pend_reg || cmd_disarm) ? ETAC_IDLE : ETAC_WAIT;
				end
		endcase
	end

	wire in_frame = (state_reg == ETAC_EXPOSE) || (state_reg == ETAC_BUSY);
	wire start_exp = state_reg == ETAC_WAIT && state_next == ETAC_EXPOSE;

	// state, arm flag and pending stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= ETAC_IDLE;
			armed_reg     <= 1'b0;
			stop_pend_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			// arm refused mid-frame; host must wait out readout
			armed_reg     <= cmd_disarm ? 1'b0 : (cmd_arm && !in_frame) ? 1'b1 : armed_reg;
			stop_pend_reg <= (in_frame && cmd_disarm) || (stop_pend_reg && in_frame);
		end
	end

	// ----------------------------------------------------------------
	// exposure timer, free-run pacing, line delay
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_cnt_reg  <= 8'h00;
			exp_cnt_reg <= 32'h0000_0000;
			fr_cnt_reg  <= 32'h0000_0000;
		end else begin
			us_cnt_reg  <= (us_tick || start_exp) ? 8'h00 : us_cnt_reg + 8'h01;
			if (start_exp) begin
				exp_cnt_reg <= expt_us;
			end else if (us_tick && exp_cnt_reg != 32'h0000_0000) begin
				exp_cnt_reg <= exp_cnt_reg - 32'h0000_0001;
			end
			// period counts clock cycles of microseconds in free-run only
			if (state_reg == ETAC_IDLE || trig_mode) begin
				fr_cnt_reg <= 32'h0000_0000;
			end else if (fr_tick && state_reg == ETAC_WAIT) begin
				fr_cnt_reg <= per_us * 32'(US_CYCLES) - 32'h0000_0001;
			end else if (!fr_tick) begin
				fr_cnt_reg <= fr_cnt_reg - 32'h0000_0001;
			end
		end
	end

	// line delay: one outstanding delayed edge at a time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_cnt_reg  <= 32'h0000_0000;
			dly_run_reg  <= 1'b0;
			dly_fire_reg <= 1'b0;
		end else begin
			dly_fire_reg <= dly_run_reg && dly_cnt_reg == 32'h0000_0000;
			if (line_edge && !dly_run_reg) begin
				dly_run_reg <= 1'b1;
				dly_cnt_reg <= tdly_reg * 32'(US_CYCLES);
			end else if (dly_run_reg && dly_cnt_reg == 32'h0000_0000) begin
				dly_run_reg <= 1'b0;
			end else if (dly_run_reg) begin
				dly_cnt_reg <= dly_cnt_reg - 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// input history and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cc1_q_reg  <= 1'b0;
			line_q_reg <= 1'b0;
			hout_q_reg <= 1'b0;
			exp_reg    <= 1'b0;
			fs_reg     <= 1'b0;
			fcnt_reg   <= 32'h0000_0000;
		end else begin
			cc1_q_reg  <= cc1;
			line_q_reg <= hw_trig_line;
			hout_q_reg <= host_out_bit;
			exp_reg    <= state_next == ETAC_EXPOSE;
			fs_reg     <= start_exp;
			fcnt_reg   <= fcnt_reg + {31'h0, start_exp};
		end
	end

	// ----------------------------------------------------------------
	// apb registers; one wait state, then a one-cycle answer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg    <= ETAC_CFG_RST;
			expt_reg   <= ETAC_EXPT_RST;
			period_reg <= ETAC_PERIOD_RST;
			minper_reg <= ETAC_MINPER_RST;
			tdly_reg   <= ETAC_TDLY_RST;
		end else begin
			// mode bit frozen while armed; other fields stay writable
			if (wr && hit_cfg) begin
				cfg_reg <= {19'h0, pwdata[12:8], 4'h0, pwdata[3:1],
					(armed_reg || in_frame) ? cfg_reg[0] : pwdata[0]};
			end
			if (wr && hit_exp) expt_reg <= pwdata;
			if (wr && hit_per) period_reg <= pwdata;
			if (wr && hit_min) minper_reg <= pwdata;
			if (wr && hit_dly) tdly_reg <= pwdata;
		end
	end

	wire [31:0] rd_mux = hit_cfg ? cfg_reg : hit_exp ? expt_reg
		: hit_per ? period_reg : hit_min ? minper_reg : hit_dly ? tdly_reg
		: hit_st ? {28'h0, stop_pend_reg, state_reg == ETAC_WAIT, in_frame, armed_reg}
		: hit_fc ? fcnt_reg : 32'h0000_0000;

	// answer registered; an unmapped address errors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= access;
			pslverr_reg <= access && !mapped;
			prdata_reg  <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign exposure    = exp_reg;
	assign frame_start = fs_reg;
	assign acq_armed   = armed_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_no_frame_unarmed;
		@(posedge pclk) disable iff (!presetn)
		!armed_reg |=> !fs_reg;
	endproperty
	a_no_frame_unarmed: assert property (p_no_frame_unarmed)
		else $error("frame started while disarmed");

	property p_disarm_idle;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ETAC_WAIT && cmd_disarm) |=> state_reg == ETAC_IDLE;
	endproperty
	a_disarm_idle: assert property (p_disarm_idle)
		else $error("disarm while waiting did not stop");

	property p_disarm_frame;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ETAC_EXPOSE && cmd_disarm) |=> state_reg != ETAC_IDLE;
	endproperty
	a_disarm_frame: assert property (p_disarm_frame)
		else $error("frame aborted by disarm");

	property p_arm_ignored;
		@(posedge pclk) disable iff (!presetn)
		(in_frame && !armed_reg && cmd_arm && !cmd_disarm) |=> !armed_reg;
	endproperty
	a_arm_ignored: assert property (p_arm_ignored)
		else $error("arm taken during frame");

	property p_mode_frozen;
		@(posedge pclk) disable iff (!presetn)
		armed_reg |=> $stable(cfg_reg[0]);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen)
		else $error("trigger mode changed while armed");

	property p_sw_trig;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ETAC_WAIT && armed_reg && !cmd_disarm && trig_mode && sel_sw
			&& cmd_swtrig) |=> fs_reg ##0 exp_reg;
	endproperty
	a_sw_trig: assert property (p_sw_trig)
		else $error("software trigger lost");

	property p_busy_ignore;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ETAC_BUSY) |=> !fs_reg;
	endproperty
	a_busy_ignore: assert property (p_busy_ignore)
		else $error("trigger taken while not ready");

	property p_return_wait;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ETAC_BUSY && !sensor_busy && !stop_pend_reg && !cmd_disarm)
			|=> state_reg == ETAC_WAIT;
	endproperty
	a_return_wait: assert property (p_return_wait)
		else $error("no return to waiting after readout");

	property p_freerun_start;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ETAC_WAIT && armed_reg && !cmd_disarm && !trig_mode && fr_tick)
			|=> fs_reg;
	endproperty
	a_freerun_start: assert property (p_freerun_start)
		else $error("free-run trigger not taken");

	property p_width_end;
		@(posedge pclk) disable iff (!presetn)
		(state_reg == ETAC_EXPOSE && use_width && level_end) |=> !exp_reg;
	endproperty
	a_width_end: assert property (p_width_end)
		else $error("width exposure did not end on closing edge");

	property p_fs_single;
		@(posedge pclk) disable iff (!presetn)
		fs_reg |=> !fs_reg;
	endproperty
	a_fs_single: assert property (p_fs_single)
		else $error("second start while exposing");

	property p_delay_hold;
		@(posedge pclk) disable iff (!presetn)
		(dly_run_reg && dly_cnt_reg != 32'h0000_0000) |=> !dly_fire_reg;
	endproperty
	a_delay_hold: assert property (p_delay_hold)
		else $error("delayed line trigger fired early");
endmodule

// >>> sim/etac_far_end.sv
// far-side model: grabber trigger line, hardware line and sensor readout
// assumes it shares pclk with the block and sees its exposure output
module etac_far_end (
	input  wire logic pclk,
	input  wire logic exposure,
	output logic      cc1,
	output logic      hw_trig_line,
	output logic      sensor_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	int readout_cycles;
	int rd_cnt;
	// ----------------------------------------------------------------
	// sensor readout
	// ----------------------------------------------------------------
	initial begin
		cc1 = 1'b0;
		hw_trig_line = 1'b0;
		rd_cnt = 0;
		readout_cycles = 4;
	end
	// readout follows exposure; a long value models a slow sensor
	always @(posedge pclk) begin
		if (exposure)
			rd_cnt <= readout_cycles;
		else if (rd_cnt != 0)
			rd_cnt <= rd_cnt - 1;
	end
	assign sensor_busy = !exposure && (rd_cnt != 0);
	// ----------------------------------------------------------------
	// trigger pulse, high for w cycles, on cc1 or the hardware line
	// ----------------------------------------------------------------
	task automatic pulse(input bit on_line, input int w);
		@(posedge pclk);
		if (on_line) begin
			hw_trig_line <= 1'b1;
		end else begin
			cc1 <= 1'b1;
		end
		repeat (w) @(posedge pclk);
		if (on_line) begin
			hw_trig_line <= 1'b0;
		end else begin
			cc1 <= 1'b0;
		end
	endtask
endmodule

// >>> sim/exposure_trigger_acquisition_control_tb.sv
// testbench: apb command sequences against the trigger control block
// assumes etac_pkg compiled first and the far-side model beside it
module exposure_trigger_acquisition_control_tb
	import etac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int US = 4;
	localparam logic [11:0] R_OFS [5] = '{ETAC_CFG_OFS, ETAC_EXPT_OFS,
		ETAC_PERIOD_OFS, ETAC_MINPER_OFS, ETAC_TDLY_OFS};
	localparam logic [31:0] R_VAL [5] = '{ETAC_CFG_RST, ETAC_EXPT_RST,
		ETAC_PERIOD_RST, ETAC_MINPER_RST, ETAC_TDLY_RST};
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        pready, pslverr, errv, cc1, hw_trig_line, sensor_busy;
	logic        exposure, frame_start, acq_armed;
	int          miscompares, cmp_count, starts, exp_len, last_len, cyc;
	int          t_prev, t_last, n0;
	etac_ctrl #(.US_CYCLES(US)) u_etac_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cc1(cc1), .hw_trig_line(hw_trig_line), .sensor_busy(sensor_busy),
		.exposure(exposure), .frame_start(frame_start), .acq_armed(acq_armed));
	etac_far_end u_etac_far_end (.pclk(pclk), .exposure(exposure), .cc1(cc1),
		.hw_trig_line(hw_trig_line), .sensor_busy(sensor_busy));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic in_range(input string nm, input int v, input int lo, input int hi);
		check(nm, 32'h1, {31'h0, (v >= lo && v <= hi)});
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge pclk);
	endtask
	function automatic logic [31:0] cfg(input logic m, a, wd, h, input logic [4:0] s);
		return {19'h0, s, 4'h0, h, wd, a, m};
	endfunction
	// disarm, wait out a readout, set the mode, arm again
	task automatic rearm(input logic [31:0] c);
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0002);
		cyc_wait(60);
		check("armed_after_disarm", 32'h0, {31'h0, acq_armed});
		apb(1'b1, ETAC_CFG_OFS, c);
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0001);
		cyc_wait(2);
	endtask
	// ----------------------------------------------------------------
	// clock, monitors and timeout
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// frame starts, their spacing and the length of the last exposure
	always @(posedge pclk) begin
		cyc++;
		if (frame_start === 1'b1) begin
			starts++;
			t_prev = t_last;
			t_last = cyc;
		end
		if (exposure === 1'b1)
			exp_len++;
		else if (exp_len != 0) begin
			last_len = exp_len;
			exp_len = 0;
		end
		if (cyc == 6000) begin
			miscompares++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, R_OFS[i], 32'h0);
			check("reset_value", R_VAL[i], rdv);
		end
		apb(1'b0, 12'h0FC, 32'h0);
		check("unmapped_err", 32'h1, {31'h0, errv});
		apb(1'b1, ETAC_CFG_OFS, cfg(1'b1, 1'b1, 1'b0, 1'b0, ETAC_SRC_SW));
		apb(1'b1, ETAC_EXPT_OFS, 32'h0000_0002);
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0004);
		cyc_wait(20);
		check("starts_unarmed", 32'h0, starts);
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0001);
		cyc_wait(2);
		check("armed", 32'h1, {31'h0, acq_armed});
		for (int k = 0; k < 2; k++) begin
			n0 = starts;
			apb(1'b1, ETAC_CMD_OFS, 32'h0000_0004);
			apb(1'b1, ETAC_CMD_OFS, 32'h0000_0004);
			cyc_wait(40);
			check("sw_frames", n0 + 1, starts);
			in_range("sw_exp_len", last_len, 2 * US, 3 * US);
		end
		apb(1'b1, ETAC_CFG_OFS, cfg(1'b0, 1'b1, 1'b0, 1'b0, ETAC_SRC_SW));
		apb(1'b0, ETAC_CFG_OFS, 32'h0);
		check("mode_locked", 32'h1, {31'h0, rdv[0]});
		// cc1 and hardware line, both polarities, timed exposure
		for (int k = 0; k < 4; k++) begin
			rearm(cfg(1'b1, k[0], 1'b0, 1'b0, k[1] ? ETAC_SRC_LINE : ETAC_SRC_CC1));
			n0 = starts;
			u_etac_far_end.pulse(k[1], 5);
			check("edge_polarity", n0 + k[0], starts);
			cyc_wait(30);
			check("ext_frame", n0 + 1, starts);
			in_range("timed_len", last_len, 2 * US, 3 * US);
		end
		rearm(cfg(1'b1, 1'b1, 1'b1, 1'b0, ETAC_SRC_CC1));
		u_etac_far_end.pulse(1'b0, 20);
		cyc_wait(30);
		in_range("width_len", last_len, 18, 22);
		// host output bit as trigger, then as exposure width
		rearm(cfg(1'b1, 1'b1, 1'b0, 1'b0, ETAC_SRC_HOUT));
		n0 = starts;
		apb(1'b1, ETAC_CFG_OFS, cfg(1'b1, 1'b1, 1'b0, 1'b1, ETAC_SRC_HOUT));
		apb(1'b1, ETAC_CFG_OFS, cfg(1'b1, 1'b1, 1'b0, 1'b0, ETAC_SRC_HOUT));
		cyc_wait(30);
		check("hout_frame", n0 + 1, starts);
		rearm(cfg(1'b1, 1'b1, 1'b1, 1'b0, ETAC_SRC_HOUT));
		apb(1'b1, ETAC_CFG_OFS, cfg(1'b1, 1'b1, 1'b1, 1'b1, ETAC_SRC_HOUT));
		cyc_wait(20);
		apb(1'b1, ETAC_CFG_OFS, cfg(1'b1, 1'b1, 1'b1, 1'b0, ETAC_SRC_HOUT));
		cyc_wait(30);
		in_range("hout_width", last_len, 22, 26);
		// delayed hardware line
		apb(1'b1, ETAC_TDLY_OFS, 32'h0000_0003);
		rearm(cfg(1'b1, 1'b1, 1'b0, 1'b0, ETAC_SRC_TIMER));
		n0 = starts;
		u_etac_far_end.pulse(1'b1, 2);
		cyc_wait(3 * US - 1);
		check("timer_early", n0, starts);
		cyc_wait(20);
		check("timer_frame", n0 + 1, starts);
		// disarm and arm during a long frame with a slow readout
		apb(1'b1, ETAC_EXPT_OFS, 32'h0000_000A);
		rearm(cfg(1'b1, 1'b1, 1'b0, 1'b0, ETAC_SRC_SW));
		u_etac_far_end.readout_cycles = 40;
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0004);
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0002);
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0001);
		cyc_wait(100);
		in_range("frame_finished", last_len, 10 * US, 11 * US);
		check("arm_ignored", 32'h0, {31'h0, acq_armed});
		n0 = starts;
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0004);
		cyc_wait(20);
		check("stopped", n0, starts);
		u_etac_far_end.readout_cycles = 4;
		// free run: set period, then a larger minimum period
		apb(1'b1, ETAC_EXPT_OFS, 32'h0000_0001);
		apb(1'b1, ETAC_PERIOD_OFS, 32'h0000_0003);
		rearm(cfg(1'b0, 1'b1, 1'b0, 1'b0, ETAC_SRC_SW));
		cyc_wait(60);
		in_range("freerun_period", t_last - t_prev, 3 * US, 3 * US + 1);
		in_range("freerun_exp_len", last_len, US, 2 * US);
		apb(1'b1, ETAC_MINPER_OFS, 32'h0000_0005);
		cyc_wait(60);
		in_range("freerun_limit", t_last - t_prev, 5 * US, 5 * US + 1);
		apb(1'b1, ETAC_CMD_OFS, 32'h0000_0002);
		cyc_wait(20);
		n0 = starts;
		cyc_wait(60);
		check("freerun_stop", n0, starts);
		give_verdict();
	end
endmodule
